// File: rtl/e3rx_monitor.sv
// Purpose: Remote failure defect tracking while the parity check is off, and parity nibble check on received E3 frames
// Assumes: Frame markers come from aligner logic on pclk; APB slave answers with no wait state
// Notes:   Interrupt status bits clear on read or by writing one; set beats clear
`timescale 1ns/10ps
module e3rx_monitor
  import e3rx_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [E3RX_AW-1:0]  paddr,
  input  wire logic [E3RX_DW-1:0]  pwdata,
  input  wire logic [3:0]          pstrb,
  output      logic [E3RX_DW-1:0]  prdata,
  output      logic                pready,
  output      logic                pslverr,
  input  wire e3rx_frame_s         rx_frame,
  output      logic                remote_failure_defect_flag,
  output      logic                parity_error_pulse,
  output      logic                irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  cfg_one_reg,   cfg_one_next;
  logic        lof_sel_reg,   lof_sel_next;
  logic        defect_reg,    defect_next;
  logic [2:0]  run_reg,       run_next;
  logic [7:0]  int_stat_reg,  int_stat_next;
  logic [7:0]  int_mask_reg,  int_mask_next;
  logic [3:0]  bip_acc_reg,   bip_acc_next;
  logic [1:0]  bit_pos_reg,   bit_pos_next;
  logic [3:0]  bip_prev_reg,  bip_prev_next;
  logic        prev_ok_reg,   prev_ok_next;
  logic        acc_live_reg,  acc_live_next;
  logic        perr_reg,      perr_next;
  logic [15:0] perr_cnt_reg,  perr_cnt_next;
  logic [7:0]  perr_lsb_reg,  perr_lsb_next;
  logic [E3RX_DW-1:0] prdata_reg, prdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [15:0] idx;
  logic        hit;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic        chk_en;
  logic        run_sel;
  logic [2:0]  run_len;
  logic        eff_alarm;
  logic        reached;
  logic        perr_evt;
  logic        change_evt;
  logic [3:0]  bip_frame;
  logic [7:0]  rd_byte;
  logic [7:0]  int_clr;

  assign idx     = {2'h0, paddr[E3RX_AW-1:2]};
  assign hit     = (idx == E3RX_IDX_CFG_ONE) || (idx == E3RX_IDX_CFG_TWO) ||
                   (idx == E3RX_IDX_INT_STAT) || (idx == E3RX_IDX_INT_MASK) ||
                   (idx == E3RX_IDX_PERR_MSB) || (idx == E3RX_IDX_PERR_LSB);
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && hit && pstrb[0];
  assign rd_acc  = psel && penable && !pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_reg;

  assign chk_en  = cfg_one_reg[E3RX_CFG1_CHK_EN];
  assign run_sel = cfg_one_reg[E3RX_CFG1_RUN_SEL];
  assign run_len = run_sel ? E3RX_RUN_LONG : E3RX_RUN_SHORT;

  ////////////////////////////////////////////////////////////////////////////
  // Remote failure defect run counting
  always_comb begin
    eff_alarm   = rx_frame.alarm && !chk_en;
    reached     = 1'b0;
    run_next    = run_reg;
    defect_next = defect_reg;
    if (rx_frame.alarm_valid) begin
      if (eff_alarm == defect_reg) begin
        run_next = 3'h0;
      end else if (run_reg + 3'h1 >= run_len) begin
        reached     = 1'b1;
        run_next    = 3'h0;
        defect_next = eff_alarm;
      end else begin
        run_next = run_reg + 3'h1;
      end
    end
    change_evt = reached;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interleaved parity over each frame
  always_comb begin
    bip_frame     = bip_acc_reg;
    bip_acc_next  = bip_acc_reg;
    bit_pos_next  = bit_pos_reg;
    bip_prev_next = bip_prev_reg;
    prev_ok_next  = prev_ok_reg;
    acc_live_next = acc_live_reg;
    perr_evt      = 1'b0;
    if (!chk_en) begin
      bip_acc_next  = 4'h0;
      bit_pos_next  = 2'h0;
      prev_ok_next  = 1'b0;
      acc_live_next = 1'b0;
    end else begin
      if (rx_frame.nibble_valid && prev_ok_reg) begin
        perr_evt = (rx_frame.nibble != bip_prev_reg);
      end
      if (rx_frame.bit_valid) begin
        if (rx_frame.sof) begin
          bip_prev_next = bip_acc_reg;
          // Only a frame accumulated from its own start is worth comparing
          prev_ok_next  = acc_live_reg;
          acc_live_next = 1'b1;
          bip_frame     = 4'h0;
          bit_pos_next  = 2'h1;
          bip_frame[0]  = rx_frame.bit_val;
        end else begin
          bip_frame[bit_pos_reg] = bip_acc_reg[bit_pos_reg] ^ rx_frame.bit_val;
          bit_pos_next = bit_pos_reg + 2'h1;
        end
        bip_acc_next = bip_frame;
      end
    end
    perr_next = perr_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, status and counter
  always_comb begin
    cfg_one_next  = cfg_one_reg;
    lof_sel_next  = lof_sel_reg;
    int_mask_next = int_mask_reg;
    int_clr       = 8'h00;
    perr_lsb_next = perr_lsb_reg;
    perr_cnt_next = perr_cnt_reg;
    if (wr_acc && idx == E3RX_IDX_CFG_ONE) begin
      cfg_one_next = pwdata[7:0] & ((8'h01 << E3RX_CFG1_RUN_SEL) | (8'h01 << E3RX_CFG1_CHK_EN));
    end
    if (wr_acc && idx == E3RX_IDX_CFG_TWO) begin
      lof_sel_next = pwdata[E3RX_CFG2_LOF_SEL];
    end
    if (wr_acc && idx == E3RX_IDX_INT_MASK) begin
      int_mask_next = pwdata[7:0] & E3RX_INT_WMASK;
    end
    if (wr_acc && idx == E3RX_IDX_INT_STAT) begin
      int_clr = pwdata[7:0];
    end
    if (rd_acc && idx == E3RX_IDX_INT_STAT) begin
      // Clear only what the setup edge captured, so a later event survives
      int_clr = prdata_reg[7:0];
    end
    if (rd_acc && idx == E3RX_IDX_PERR_MSB) begin
      perr_lsb_next = perr_cnt_reg[7:0];
      perr_cnt_next = 16'h0000;
    end
    if (perr_evt && perr_cnt_next != E3RX_CNT_MAX) begin
      perr_cnt_next = perr_cnt_next + 16'h0001;
    end
    int_stat_next = int_stat_reg & ~int_clr & E3RX_INT_WMASK;
    int_stat_next[E3RX_INT_CHANGE] = int_stat_next[E3RX_INT_CHANGE] | change_evt;
    int_stat_next[E3RX_INT_PERR]   = int_stat_next[E3RX_INT_PERR] | perr_evt;

    rd_byte = 8'h00;
    case (idx)
      E3RX_IDX_CFG_ONE:  rd_byte = cfg_one_reg;
      E3RX_IDX_CFG_TWO:  rd_byte = ({7'h00, lof_sel_reg} << E3RX_CFG2_LOF_SEL) |
                                   ({7'h00, defect_reg} << E3RX_CFG2_DEFECT);
      E3RX_IDX_INT_STAT: rd_byte = int_stat_reg;
      E3RX_IDX_INT_MASK: rd_byte = int_mask_reg;
      E3RX_IDX_PERR_MSB: rd_byte = perr_cnt_reg[15:8];
      E3RX_IDX_PERR_LSB: rd_byte = perr_lsb_reg;
      default:           rd_byte = 8'h00;
    endcase
    prdata_next = prdata_reg;
    if (setup && !pwrite) begin
      prdata_next = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_one_reg  <= E3RX_CFG1_RST;
      lof_sel_reg  <= 1'b0;
      defect_reg   <= 1'b0;
      run_reg      <= 3'h0;
      int_stat_reg <= 8'h00;
      int_mask_reg <= E3RX_INT_MASK_RST;
      bip_acc_reg  <= 4'h0;
      bit_pos_reg  <= 2'h0;
      bip_prev_reg <= 4'h0;
      prev_ok_reg  <= 1'b0;
      acc_live_reg <= 1'b0;
      perr_reg     <= 1'b0;
      perr_cnt_reg <= 16'h0000;
      perr_lsb_reg <= 8'h00;
      prdata_reg   <= 32'h00000000;
    end else begin
      cfg_one_reg  <= cfg_one_next;
      lof_sel_reg  <= lof_sel_next;
      defect_reg   <= defect_next;
      run_reg      <= run_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      bip_acc_reg  <= bip_acc_next;
      bit_pos_reg  <= bit_pos_next;
      bip_prev_reg <= bip_prev_next;
      prev_ok_reg  <= prev_ok_next;
      acc_live_reg <= acc_live_next;
      perr_reg     <= perr_next;
      perr_cnt_reg <= perr_cnt_next;
      perr_lsb_reg <= perr_lsb_next;
      prdata_reg   <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign remote_failure_defect_flag = defect_reg;
  assign parity_error_pulse         = perr_reg;
  assign irq_n = ~|(int_stat_reg & int_mask_reg);

endmodule

// File: shared/e3rx_pkg.sv
// Purpose: Shared constants and types for the E3 receive defect and parity monitor
// Assumes: APB with 32-bit data, register index times four gives the byte address
// Notes:   Register indices keep the printed offsets
package e3rx_pkg;

  localparam int          E3RX_AW            = 16;
  localparam int          E3RX_DW            = 32;

  // Register indices, byte address is four times the index
  localparam logic [15:0] E3RX_IDX_CFG_ONE   = 16'h1110;
  localparam logic [15:0] E3RX_IDX_CFG_TWO   = 16'h1111;
  localparam logic [15:0] E3RX_IDX_INT_STAT  = 16'h1115;
  localparam logic [15:0] E3RX_IDX_INT_MASK  = 16'h1117;
  localparam logic [15:0] E3RX_IDX_PERR_MSB  = 16'h1154;
  localparam logic [15:0] E3RX_IDX_PERR_LSB  = 16'h1155;

  // Field positions
  localparam int          E3RX_CFG1_CHK_EN   = 0;
  localparam int          E3RX_CFG1_RUN_SEL  = 4;
  localparam int          E3RX_CFG2_DEFECT   = 0;
  localparam int          E3RX_CFG2_LOF_SEL  = 7;
  localparam int          E3RX_INT_PERR      = 2;
  localparam int          E3RX_INT_CHANGE    = 3;

  // Reset values and interrupt write mask
  localparam logic [7:0]  E3RX_CFG1_RST      = 8'h00;
  localparam logic [7:0]  E3RX_INT_MASK_RST  = 8'h00;
  localparam logic [7:0]  E3RX_INT_WMASK     = 8'h0c;

  // Consecutive frame run lengths
  localparam logic [2:0]  E3RX_RUN_SHORT     = 3'h3;
  localparam logic [2:0]  E3RX_RUN_LONG      = 3'h5;

  localparam logic [15:0] E3RX_CNT_MAX       = 16'hffff;

  // One received bit, with markers placed by the frame aligner
  typedef struct packed {
    logic       sof;
    logic       bit_valid;
    logic       bit_val;
    logic       alarm_valid;
    logic       alarm;
    logic       nibble_valid;
    logic [3:0] nibble;
  } e3rx_frame_s;

endpackage

// File: testbench/e3rx_remote_tx.sv
// Purpose: Far-end transmitter model driving the received frame stream
// Assumes: Short frames of FRAME_BITS bits, one idle cycle between frames
// Notes:   Unqualified fields carry inverted values while idle
`timescale 1ns/10ps
module e3rx_remote_tx
  import e3rx_pkg::*;
#(
  parameter int FRAME_BITS = 16
)(
  input  wire logic   pclk,
  output e3rx_frame_s rx_frame
);
  logic [3:0] prev_par;
  int         fno;
  initial begin
    rx_frame = '0;
    prev_par = 4'h0;
    fno = 0;
  end
  task automatic send_frame(input logic a, input logic bad);
    logic [3:0] acc;
    logic       b;
    acc = 4'h0;
    b = 1'b0;
    for (int k = 0; k < FRAME_BITS; k++) begin
      b = ^(k * 5 + fno * 3);
      @(posedge pclk);
      rx_frame <= '{sof: k == 0, bit_valid: 1'b1, bit_val: b, alarm_valid: k == 1, alarm: a,
                    nibble_valid: k == 2, nibble: prev_par ^ {4{bad}}};
      acc[k % 4] = acc[k % 4] ^ b;
    end
    prev_par = acc;
    fno++;
    @(posedge pclk);
    rx_frame <= {2'b00, ~b, 1'b0, ~a, 1'b0, ~prev_par};
  endtask
endmodule

// File: testbench/e3rx_properties.sv
// Purpose: Port checker for the E3 receive monitor
// Assumes: One pclk domain, presetn active low
// Notes:   Helper counters track runs of effective alarm values
`timescale 1ns/10ps
module e3rx_chk
  import e3rx_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [E3RX_AW-1:0] paddr,
  input wire logic [E3RX_DW-1:0] pwdata,
  input wire logic [3:0]         pstrb,
  input wire e3rx_frame_s        rx_frame,
  input wire logic               remote_failure_defect_flag,
  input wire logic               parity_error_pulse,
  input wire logic               irq_n
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] ones_reg, ones_next, zero_reg, zero_next;
  logic       chk_reg, chk_next, eff, flg, av;
  assign eff = rx_frame.alarm && !chk_reg;
  assign flg = remote_failure_defect_flag;
  assign av = rx_frame.alarm_valid;
  always_comb begin
    chk_next = chk_reg;
    ones_next = ones_reg;
    zero_next = zero_reg;
    if (psel && penable && pwrite && pstrb[0] && paddr[15:2] == E3RX_IDX_CFG_ONE[13:0]) chk_next = pwdata[0];
    if (av) begin
      ones_next = eff ? ones_reg + {2'b00, ones_reg != 3'h7} : 3'h0;
      zero_next = eff ? 3'h0 : zero_reg + {2'b00, zero_reg != 3'h7};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {chk_reg, ones_reg, zero_reg} <= 7'h00;
    else {chk_reg, ones_reg, zero_reg} <= {chk_next, ones_next, zero_next};
  end
  decl_run_a: assert property ($rose(flg) |-> ones_reg >= 3'h3)
    else $error("defect declared early");
  clear_run_a: assert property ($fell(flg) |-> zero_reg >= 3'h3)
    else $error("defect cleared early");
  decl_due_a: assert property (av && eff && ones_reg == 3'h4 |=> flg)
    else $error("defect not declared");
  clear_due_a: assert property (av && !eff && zero_reg == 3'h4 |=> !flg)
    else $error("defect not cleared");
  chk_gate_a: assert property (parity_error_pulse |-> $past(rx_frame.nibble_valid && chk_reg))
    else $error("parity error without enabled compare");
  pulse_one_a: assert property (parity_error_pulse |=> !parity_error_pulse)
    else $error("parity error pulse too long");
  irq_fall_a: assert property ($fell(irq_n) |-> parity_error_pulse || $changed(flg) || $past(psel && pwrite))
    else $error("interrupt without cause");
  irq_rise_a: assert property ($rose(irq_n) |-> $past(psel && penable))
    else $error("interrupt released without access");
  cover property ($rose(flg));
  cover property ($fell(flg));
  cover property (parity_error_pulse);
endmodule
bind e3rx_monitor e3rx_chk e3rx_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .rx_frame(rx_frame),
  .remote_failure_defect_flag(remote_failure_defect_flag), .parity_error_pulse(parity_error_pulse), .irq_n(irq_n));

// File: testbench/e3rx_tb.sv
// Purpose: Self-checking bench for the E3 receive monitor
// Assumes: APB answers by pready, frames from the far-end model
// Notes:   Short frames keep the run brief
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import e3rx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, flag, pulse, irq_n, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  e3rx_frame_s rx_frame;
  int          failures, cmp_count, pulses, n;
  e3rx_monitor e3rx_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .remote_failure_defect_flag(flag), .parity_error_pulse(pulse), .irq_n(irq_n));
  e3rx_remote_tx #(.FRAME_BITS(16)) e3rx_remote_tx_i (.pclk(pclk), .rx_frame(rx_frame));
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (pulse === 1'b1) pulses++;
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {idx[13:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask
  task automatic frames(input int cnt, input logic a, input logic bad);
    repeat (cnt) e3rx_remote_tx_i.send_frame(a, bad);
  endtask
  task automatic final_report;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(E3RX_IDX_CFG_ONE, E3RX_CFG1_RST);
    rd_chk(E3RX_IDX_INT_MASK, E3RX_INT_MASK_RST);
    rd_chk(E3RX_IDX_INT_STAT, 8'h00);
    apb(1'b0, 16'h1112, 8'h00);
    `CHK({err, rd}, 33'h100000000)
    apb(1'b1, E3RX_IDX_INT_MASK, E3RX_INT_WMASK);
    rd_chk(E3RX_IDX_INT_MASK, E3RX_INT_WMASK);
    for (int s = 0; s < 2; s++) begin
      n = s ? 5 : 3;
      apb(1'b1, E3RX_IDX_CFG_ONE, {3'h0, s[0], 4'h0});
      frames(n - 1, 1'b1, 1'b0);
      frames(1, 1'b0, 1'b0);
      frames(n - 1, 1'b1, 1'b0);
      `CHK(flag, 1'b0)
      frames(1, 1'b1, 1'b0);
      `CHK({flag, irq_n}, 2'b10)
      rd_chk(E3RX_IDX_CFG_TWO, 8'h01);
      rd_chk(E3RX_IDX_INT_STAT, 8'h08);
      frames(n - 1, 1'b0, 1'b0);
      frames(1, 1'b1, 1'b0);
      frames(n - 1, 1'b0, 1'b0);
      `CHK(flag, 1'b1)
      frames(1, 1'b0, 1'b0);
      `CHK({flag, irq_n}, 2'b00)
      rd_chk(E3RX_IDX_CFG_TWO, 8'h00);
      rd_chk(E3RX_IDX_INT_STAT, 8'h08);
      @(posedge pclk);
      `CHK(irq_n, 1'b1)
    end
    apb(1'b1, E3RX_IDX_CFG_ONE, 8'h01);
    frames(3, 1'b1, 1'b0);
    `CHK(flag, 1'b0)
    `CHK(pulses, 0)
    frames(1, 1'b0, 1'b1);
    `CHK(pulses, 1)
    `CHK(irq_n, 1'b0)
    rd_chk(E3RX_IDX_INT_STAT, 8'h04);
    rd_chk(E3RX_IDX_PERR_MSB, 8'h00);
    rd_chk(E3RX_IDX_PERR_LSB, 8'h01);
    apb(1'b1, E3RX_IDX_CFG_ONE, 8'h00);
    frames(2, 1'b0, 1'b1);
    `CHK(pulses, 1)
    rd_chk(E3RX_IDX_INT_STAT, 8'h00);
    final_report;
  end
endmodule
